// file: sim/overtemp_threshold_compare_bench.sv
// self-checking bench for the overtemperature threshold block
module overtemp_threshold_compare_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import overtemp_pkg::*;

  localparam int DB = 16;
  logic        clk, rst, rd, wr, waitreq, neg, flag;
  logic [17:0] addr;
  logic [3:0]  be;
  logic [31:0] wd, rdata, q;
  logic [11:0] tgt, val;
  logic [6:0]  mag;
  int          miscompares, total_checks, seed, r, thr, v;

  overtemp_threshold_compare #(.VALUE_W(12), .DEBOUNCE_CYCLES(DB)) i_overtemp_threshold_compare (
    .i_clk_sys(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_byteenable(be), .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_sense_one_value(val), .o_trim_two_negative(neg), .o_trim_two_magnitude(mag),
    .o_overtemp_one_flag(flag));

  sense_source i_sense_source (.i_clk_sys(clk), .i_target(tgt), .o_value(val));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // one avalon access; holds the request until waitrequest is seen low
  task acc(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    rd   <= !w;
    wr   <= w;
    addr <= {idx, 2'b00};
    wd   <= d;
    be   <= b;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) miscompares++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc

  task hold(input logic [11:0] t, input int n, input logic e);
    @(posedge clk);
    tgt <= t;
    repeat (n) @(posedge clk);
    @(negedge clk);
    check({31'h0, flag}, {31'h0, e});
  endtask : hold

  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end

  initial begin
    {rst, rd, wr, addr, be, wd, tgt} = {1'b1, 56'h0, 12'h0};
    seed = 32'ha1c1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // ***************************************************************
    // reset values and trim fields
    // ***************************************************************
    acc(1'b0, IDX_TRIM_TWO, 32'h0, 4'h1);
    check(q, {24'h0, TRIM_RESET});
    acc(1'b0, IDX_THR_ONE, 32'h0, 4'h1);
    check(q, {24'h0, THR_RESET});
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      acc(1'b1, IDX_TRIM_TWO, r, 4'h1);
      @(negedge clk);
      check({31'h0, neg}, {31'h0, r[7]});
      check({25'h0, mag}, {25'h0, r[6:0]});
    end
    // a write without the low byte lane enabled must leave the trim alone
    acc(1'b1, IDX_TRIM_TWO, ~r, 4'h0);
    acc(1'b0, IDX_TRIM_TWO, 32'h0, 4'h1);
    check(q, {24'h0, r[7:0]});
    acc(1'b0, 16'h0001, 32'h0, 4'h1);
    check(q, 32'h0);
    // ***************************************************************
    // threshold against the nine top bits, boundaries first
    // ***************************************************************
    for (int i = 0; i < 12; i++) begin
      thr = THR_MIN_CODE + ($unsigned($random(seed)) % 243);
      v = $unsigned($random(seed)) % 4096;
      if (i < 4) v = ((thr - i % 2) << 3) | i;
      acc(1'b1, IDX_THR_ONE, thr, 4'h1);
      tgt <= v[11:0];
      repeat (3) @(posedge clk);
      acc(1'b0, IDX_VALUE_ONE, 32'h0, 4'h1);
      check(q, v);
      acc(1'b0, IDX_STATUS, 32'h0, 4'h1);
      check({31'h0, q[1]}, {31'h0, thr > (v >> 3)});
    end
    // ***************************************************************
    // qualification of the flag, both directions
    // ***************************************************************
    hold(12'hfff, DB + 4, 1'b0);
    hold(12'h000, DB - 3, 1'b0);
    hold(12'hfff, DB + 4, 1'b0);
    hold(12'h000, DB - 1, 1'b0);
    hold(12'h000, 3, 1'b1);
    acc(1'b0, IDX_STATUS, 32'h0, 4'h1);
    check(q, 32'h3);
    hold(12'hfff, DB - 1, 1'b1);
    hold(12'hfff, 3, 1'b0);
    finish_test;
  end
endmodule : overtemp_threshold_compare_bench

// file: sim/sense_source.sv
// converter model that presents the commanded channel one reading
module sense_source (
  // clock
  input  wire logic        i_clk_sys,
  // commanded reading in, converter reading out
  input  wire logic [11:0] i_target,
  output logic      [11:0] o_value
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [11:0] nxt_value;

  // a conversion result only appears at a clock edge, never mid-cycle
  always_comb begin
    nxt_value = i_target;
  end

  always_ff @(posedge i_clk_sys) begin
    o_value <= nxt_value;
  end
endmodule : sense_source

// file: verilog/flag_debounce.sv
// qualification filter that lets a flag change only after a persistent condition
module flag_debounce #(
  parameter int CYCLES = 2_500_000
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // condition in, qualified flag out
  input  wire logic i_raw,
  output logic      o_flag
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             flag_ff;
  logic             nxt_flag;

  // ***************************************************************
  // timer
  // ***************************************************************
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_flag = flag_ff;
    if (i_raw == flag_ff) begin
      nxt_cnt = '0;
    end else if (cnt_ff == CNT_LAST) begin
      nxt_flag = i_raw;
      nxt_cnt  = '0;
    end else begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_ff  <= '0;
      flag_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      flag_ff <= nxt_flag;
    end
  end

  assign o_flag = flag_ff;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_flag_qualified: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (flag_ff != $past(flag_ff)) |-> ($past(cnt_ff) == CNT_LAST && $past(i_raw) != $past(flag_ff)))
    else $error("flag changed before the qualification time ran out");

  a_timer_restart: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_raw == flag_ff) |=> (cnt_ff == '0))
    else $error("timer did not restart when the condition went away");

  a_timer_advance: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_raw != flag_ff && cnt_ff != CNT_LAST) |=> (cnt_ff == $past(cnt_ff) + CNT_W'(1) && flag_ff == $past(flag_ff)))
    else $error("timer did not advance while the condition held");

endmodule : flag_debounce

// file: verilog/overtemp_pkg.sv
// constants, register map and decode for the overtemperature threshold block
package overtemp_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int CLK_HZ          = 25_000_000;
  localparam int DEBOUNCE_MS     = 100;
  localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;

  // ***************************************************************
  // bus geometry
  // ***************************************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // ***************************************************************
  // register indices, byte address is four times the index
  // ***************************************************************
  localparam logic [15:0] IDX_TRIM_TWO  = 16'hfe74;
  localparam logic [15:0] IDX_THR_ONE   = 16'hfe75;
  localparam logic [15:0] IDX_VALUE_ONE = 16'hfed7;
  localparam logic [15:0] IDX_STATUS    = 16'hfef0;

  // ***************************************************************
  // field layout and reset values
  // ***************************************************************
  localparam int         REG_W         = 8;
  localparam int         TRIM_SIGN_BIT = 7;
  localparam int         TRIM_MAG_W    = 7;
  localparam int         THR_W         = 8;
  localparam int         CMP_W         = 9;
  localparam int         STAT_FLAG_BIT = 0;
  localparam int         STAT_RAW_BIT  = 1;
  localparam logic [7:0] TRIM_RESET    = 8'h00;
  localparam logic [7:0] THR_RESET     = 8'h00;

  // ***************************************************************
  // threshold scale, informational for software
  // ***************************************************************
  localparam int THR_STEP_UV    = 3125;
  localparam int THR_FULL_MV    = 800;
  localparam int THR_CODES      = 256;
  localparam int THR_MIN_CODE   = 2;
  localparam int THR_MAX_CODE   = 244;

  typedef enum {SEL_NONE, SEL_TRIM, SEL_THR, SEL_VALUE, SEL_STATUS} sel_t;

  function automatic sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    sel_t s;
    s = SEL_NONE;
    if (addr == {IDX_TRIM_TWO, 2'b00}) begin
      s = SEL_TRIM;
    end else if (addr == {IDX_THR_ONE, 2'b00}) begin
      s = SEL_THR;
    end else if (addr == {IDX_VALUE_ONE, 2'b00}) begin
      s = SEL_VALUE;
    end else if (addr == {IDX_STATUS, 2'b00}) begin
      s = SEL_STATUS;
    end
    return s;
  endfunction : decode_addr

endpackage : overtemp_pkg

// file: verilog/overtemp_threshold_compare.sv
// sense trim registers and debounced overtemperature threshold comparison
//
// What this block does
// - trim bit 7 chooses sign: one negative gain correction, zero positive
// - trim bits 6 to 0 hold the gain correction magnitude for sense two
// - threshold is widened to nine bits with a zero on top
// - widened threshold meets the nine top bits of the sense one reading
// - raw overtemperature condition is threshold strictly above the reading
// - the overtemperature flag changes only after 100 ms of qualification
// - one threshold code is 3.125 mV, 256 codes span 0 to 800 mV
module overtemp_threshold_compare #(
  parameter int VALUE_W         = 12,
  parameter int DEBOUNCE_CYCLES = overtemp_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input  wire logic                             i_clk_sys,
  input  wire logic                             i_rst,
  // avalon-mm slave
  input  wire logic [overtemp_pkg::ADDR_W-1:0]  i_avs_address,
  input  wire logic                             i_avs_read,
  input  wire logic                             i_avs_write,
  input  wire logic [overtemp_pkg::BE_W-1:0]    i_avs_byteenable,
  input  wire logic [overtemp_pkg::DATA_W-1:0]  i_avs_writedata,
  output logic      [overtemp_pkg::DATA_W-1:0]  o_avs_readdata,
  output logic                                  o_avs_waitrequest,
  // sense converter reading, channel one
  input  wire logic [VALUE_W-1:0]               i_sense_one_value,
  // trim for sense channel two
  output logic                                  o_trim_two_negative,
  output logic      [overtemp_pkg::TRIM_MAG_W-1:0] o_trim_two_magnitude,
  // protection
  output logic                                  o_overtemp_one_flag
);

  import overtemp_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  logic [REG_W-1:0]  trim_ff;
  logic [REG_W-1:0]  nxt_trim;
  logic [THR_W-1:0]  thr_ff;
  logic [THR_W-1:0]  nxt_thr;
  logic              wait_ff;
  logic              nxt_wait;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic              cmp_ff;
  logic              nxt_cmp;
  logic              flag_q;
  sel_t              sel;
  logic              accept;
  logic [CMP_W-1:0]  thr_wide;
  logic [CMP_W-1:0]  value_top;

  // ***************************************************************
  // bus slave
  // ***************************************************************
  // every access takes one wait cycle: the answer is registered, so
  // read data and the write strobe never ride on a combinational path
  always_comb begin
    sel       = decode_addr(i_avs_address);
    accept    = (i_avs_read || i_avs_write) && !wait_ff;
    nxt_wait  = 1'b1;
    nxt_rdata = rdata_ff;
    nxt_trim  = trim_ff;
    nxt_thr   = thr_ff;
    if ((i_avs_read || i_avs_write) && wait_ff) begin
      nxt_wait  = 1'b0;
      nxt_rdata = '0;
      if (i_avs_read) begin
        case (sel)
          SEL_TRIM:   nxt_rdata = DATA_W'(trim_ff);
          SEL_THR:    nxt_rdata = DATA_W'(thr_ff);
          SEL_VALUE:  nxt_rdata = DATA_W'(i_sense_one_value);
          SEL_STATUS: begin
            nxt_rdata[STAT_FLAG_BIT] = flag_q;
            nxt_rdata[STAT_RAW_BIT]  = cmp_ff;
          end
          default:    nxt_rdata = '0;
        endcase
      end
    end
    // only the low byte lane carries writable register bits
    if (accept && i_avs_write && i_avs_byteenable[0]) begin
      case (sel)
        SEL_TRIM: nxt_trim = i_avs_writedata[REG_W-1:0];
        // codes are taken as written; keeping to 2..244 is software's job
        SEL_THR:  nxt_thr  = i_avs_writedata[THR_W-1:0];
        default:  nxt_trim = trim_ff;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
      trim_ff  <= TRIM_RESET;
      thr_ff   <= THR_RESET;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
      trim_ff  <= nxt_trim;
      thr_ff   <= nxt_thr;
    end
  end

  assign o_avs_waitrequest    = wait_ff;
  assign o_avs_readdata       = rdata_ff;
  assign o_trim_two_negative  = trim_ff[TRIM_SIGN_BIT];
  assign o_trim_two_magnitude = trim_ff[TRIM_MAG_W-1:0];

  // ***************************************************************
  // threshold comparison
  // ***************************************************************
  always_comb begin
    thr_wide  = {1'b0, thr_ff};
    value_top = i_sense_one_value[VALUE_W-1 -: CMP_W];
    nxt_cmp   = thr_wide > value_top;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cmp_ff <= 1'b0;
    end else begin
      cmp_ff <= nxt_cmp;
    end
  end

  // ***************************************************************
  // qualification
  // ***************************************************************
  flag_debounce #(
    .CYCLES    (DEBOUNCE_CYCLES)
  ) u_debounce (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_raw     (cmp_ff),
    .o_flag    (flag_q)
  );

  assign o_overtemp_one_flag = flag_q;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_trim_sign_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (accept && i_avs_write && i_avs_byteenable[0] && sel == SEL_TRIM)
      |=> (o_trim_two_negative == $past(i_avs_writedata[TRIM_SIGN_BIT])))
    else $error("trim sign did not follow the written bit 7");

  a_trim_mag_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (accept && i_avs_write && i_avs_byteenable[0] && sel == SEL_TRIM)
      |=> (o_trim_two_magnitude == $past(i_avs_writedata[TRIM_MAG_W-1:0])))
    else $error("trim magnitude did not follow the written bits");

  a_thr_compare: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) |-> (cmp_ff == ({1'b0, $past(thr_ff)} > $past(i_sense_one_value[VALUE_W-1 -: CMP_W]))))
    else $error("comparison result does not match zero-extended threshold test");

  a_value_readback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && !wait_ff && sel == SEL_VALUE) |-> (o_avs_readdata == DATA_W'($past(i_sense_one_value))))
    else $error("reading register returned the wrong value");

  a_flag_needs_cond: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_overtemp_one_flag) |-> $past(cmp_ff))
    else $error("flag set without the threshold above the reading");

  a_wait_one_cycle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read || i_avs_write) && wait_ff |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

  a_unmapped_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && !wait_ff && sel == SEL_NONE) |-> (o_avs_readdata == '0))
    else $error("unmapped read returned nonzero data");

  a_thr_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (accept && i_avs_write && i_avs_byteenable[0] && sel == SEL_THR) |=> (thr_ff == $past(i_avs_writedata[THR_W-1:0])))
    else $error("threshold register did not take the written code");

  // readback of the stored bytes, taken as they stood when the read was first seen
  a_trim_readback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && !wait_ff && sel == SEL_TRIM) |-> (o_avs_readdata == DATA_W'($past(trim_ff))))
    else $error("trim readback differs from the stored trim");

  a_thr_readback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && !wait_ff && sel == SEL_THR) |-> (o_avs_readdata == DATA_W'($past(thr_ff))))
    else $error("threshold readback differs from the stored code");

  a_status_readback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && !wait_ff && sel == SEL_STATUS)
      |-> (o_avs_readdata == DATA_W'({$past(cmp_ff), $past(flag_q)})))
    else $error("status readback differs from flag and raw result");

  // a register may only move on an accepted low-lane write to it
  a_trim_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !(accept && i_avs_write && i_avs_byteenable[0] && sel == SEL_TRIM) |=> $stable(trim_ff))
    else $error("trim changed without a write to it");

  a_thr_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !(accept && i_avs_write && i_avs_byteenable[0] && sel == SEL_THR) |=> $stable(thr_ff))
    else $error("threshold changed without a write to it");

  a_wait_idle_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
    else $error("waitrequest low without a request");

  a_rdata_stands: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !((i_avs_read || i_avs_write) && wait_ff) |=> $stable(o_avs_readdata))
    else $error("read data changed outside an access");

  a_cmp_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ({1'b0, thr_ff} <= i_sense_one_value[VALUE_W-1 -: CMP_W]) |=> !cmp_ff)
    else $error("raw condition set with the threshold not above the reading");

endmodule : overtemp_threshold_compare
